// File: include/sos_pkg.sv
// Shared constants, types and helpers for the standby oscillation stabilizer
package sos_pkg;
  localparam logic [15:0] SETTLE_STATUS_ADDR = 16'hffa3;
  localparam logic [15:0] SETTLE_SELECT_ADDR = 16'hffa4;
  localparam logic [7:0]  SETTLE_STATUS_RST  = 8'h00;
  localparam logic [2:0]  SETTLE_SELECT_RST  = 3'h5;
  localparam int          CNT_W              = 17;
  localparam int          LS_HOLD_PERIODS    = 21;
  localparam logic [4:0]  STEP_EXP [5]       = '{5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0b};
  // Host register map on APB
  localparam logic [7:0]  HOST_CMD_OFF       = 8'h00;
  localparam logic [7:0]  HOST_CTRL_OFF      = 8'h04;
  localparam logic [7:0]  HOST_STAT_OFF      = 8'h08;
  localparam logic [7:0]  HOST_DEV_STS_OFF   = 8'h10;
  localparam logic [7:0]  HOST_DEV_SEL_OFF   = 8'h14;
  localparam int          CMD_HALT_BIT       = 0;
  localparam int          CMD_STOP_BIT       = 1;
  localparam int          CMD_RST_BIT        = 2;
  localparam int          CTRL_MAIN_OFF_BIT  = 0;
  localparam int          CTRL_LS_OFF_BIT    = 1;
  localparam int          CTRL_PERIPH_BIT    = 2;
  localparam int          CTRL_SRC_LSB       = 4;
  localparam logic [5:0]  CTRL_RST           = 6'h00;

  typedef enum logic [1:0] {
    CLK_LOWSPEED    = 2'h0,
    CLK_CRYSTAL     = 2'h1,
    CLK_INTERNAL_HS = 2'h2
  } sos_clk_src_t;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_HALT = 4'h2,
    ST_STOP = 4'h4,
    ST_WAIT = 4'h8
  } sos_state_t;

  // Wait select code to exponent of crystal periods
  function automatic logic [4:0] sel_exp(input logic [2:0] sel);
    case (sel)
      3'h1:    sel_exp = 5'h0b;
      3'h2:    sel_exp = 5'h0d;
      3'h3:    sel_exp = 5'h0e;
      3'h4:    sel_exp = 5'h0f;
      default: sel_exp = 5'h10; // Prohibited codes fall back to longest
    endcase
  endfunction
endpackage

// File: include/sos_link_if.sv
// Link between the CPU-side controller and the standby device
`timescale 1ns/1ns
`default_nettype none
interface sos_link_if;
  logic        halt_req;
  logic        stop_req;
  logic        rst_req;
  logic        irq;
  logic        main_osc_off;
  logic        lowspeed_osc_off;
  logic        periph_clk_source;
  logic [1:0]  cpu_clk_src;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_ack;
  logic [7:0]  reg_rdata;
  logic        cpu_clk_en;
  logic        in_halt;
  logic        in_stop;
  logic        settling;

  modport device (
    input  halt_req, stop_req, rst_req, irq, main_osc_off, lowspeed_osc_off,
    input  periph_clk_source, cpu_clk_src, reg_wr, reg_rd, reg_addr, reg_wdata,
    output reg_ack, reg_rdata, cpu_clk_en, in_halt, in_stop, settling
  );

  modport host (
    output halt_req, stop_req, rst_req, irq, main_osc_off, lowspeed_osc_off,
    output periph_clk_source, cpu_clk_src, reg_wr, reg_rd, reg_addr, reg_wdata,
    input  reg_ack, reg_rdata, cpu_clk_en, in_halt, in_stop, settling
  );
endinterface
`default_nettype wire

// File: design/sos_settle_counter.sv
// Crystal stabilization counter with sticky step status
`timescale 1ns/1ns
`default_nettype none
module sos_settle_counter #(
  parameter int unsigned EXP_TRIM = 0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       start,
  input  wire logic       x1_tick,
  input  wire logic [2:0] sel,
  output logic [4:0]      status,
  output logic            busy,
  output logic            done
);
  import sos_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic             run_reg;
  logic [4:0]       status_reg;
  logic             done_reg;
  logic [4:0]       hit;

  wire  [4:0]       goal_exp = sel_exp(sel) - 5'(EXP_TRIM);
  wire  [CNT_W-1:0] goal_cnt = CNT_W'(1) << goal_exp;
  wire  [CNT_W-1:0] cnt_next = cnt_reg + CNT_W'(1);
  // Ticks only arrive once the crystal oscillates
  wire              step     = run_reg && x1_tick;
  wire              reached  = step && (cnt_next == goal_cnt);

  // Thresholds beyond the goal are never passed, so those bits stay clear
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      hit[i] = step && (cnt_next == (CNT_W'(1) << (STEP_EXP[i] - 5'(EXP_TRIM))));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= '0;
      run_reg <= 1'b1;
      done_reg <= 1'b0;
    end else if (clear) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (step) begin
      cnt_reg <= cnt_next;
      run_reg <= !reached;
      done_reg <= reached;
    end else begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 5'h00;
    end else if (clear) begin
      status_reg <= 5'h00;
    end else begin
      status_reg <= status_reg | hit;
    end
  end

  assign status = status_reg;
  assign busy   = run_reg;
  assign done   = done_reg;
endmodule
`default_nettype wire

// File: design/sos_device_end.sv
// Standby controller: halt and stop modes with oscillator settle timing
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sos_device_end #(
  parameter int unsigned EXP_TRIM     = 0,
  parameter int unsigned LS_HOLD      = 21
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  sos_link_if.device  link,
  input  wire logic   x1_tick,
  input  wire logic   ls_tick,
  input  wire logic   hs_is_internal,
  input  wire logic   lowspeed_can_stop,
  output logic        hs_osc_en,
  output logic        ls_osc_en,
  output logic        periph_clk_en,
  output logic        periph_clk_sel,
  output logic        hold_latches
);
  import sos_pkg::*;

  sos_state_t   state_reg;
  sos_state_t   state_next;
  sos_clk_src_t src_reg;
  logic [2:0]   select_reg;
  logic         boot_reg;
  logic [4:0]   ls_cnt_reg;
  logic         cpu_en_reg;
  logic         hs_en_reg;
  logic         ls_en_reg;
  logic         per_en_reg;
  logic         per_sel_reg;
  logic         hold_reg;
  logic         halt_flag_reg;
  logic         ack_reg;
  logic [7:0]   rdata_reg;
  logic [4:0]   settle_status;
  logic         settle_busy;
  logic         settle_done;

  wire sos_clk_src_t cur_src = sos_clk_src_t'(link.cpu_clk_src);
  wire in_run     = (state_reg == ST_RUN);
  wire enter_halt = in_run && link.halt_req;
  wire enter_stop = in_run && link.stop_req && !link.halt_req;
  wire stop_wake  = (state_reg == ST_STOP) && link.irq;
  wire ls_hold_end = (ls_cnt_reg == 5'(LS_HOLD - 1)) && ls_tick;
  wire sel_hit    = (link.reg_addr == SETTLE_SELECT_ADDR);
  wire sts_hit    = (link.reg_addr == SETTLE_STATUS_ADDR);
  // CPU is stopped in standby, so writes there cannot be genuine
  wire sel_wr     = link.reg_wr && sel_hit && in_run;
  // Reset release also starts the settle counter
  wire settle_start = !hs_is_internal &&
                      (boot_reg || link.rst_req || stop_wake);
  wire settle_clear = enter_stop || link.main_osc_off || link.rst_req;
  wire src_is_ls  = (state_reg == ST_RUN) ? (cur_src == CLK_LOWSPEED) : (src_reg == CLK_LOWSPEED);
  // Low-speed stop request honoured only when the option permits it
  wire ls_off_req = link.lowspeed_osc_off && lowspeed_can_stop && !src_is_ls;

  sos_settle_counter #(
    .EXP_TRIM (EXP_TRIM)
  ) u_settle (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (settle_clear),
    .start   (settle_start),
    .x1_tick (x1_tick),
    .sel     (select_reg),
    .status  (settle_status),
    .busy    (settle_busy),
    .done    (settle_done)
  );

  always_comb begin
    state_next = state_reg;
    if (link.rst_req) begin
      state_next = ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (enter_halt) begin
            state_next = ST_HALT;
          end else if (enter_stop) begin
            state_next = ST_STOP;
          end
        end
        ST_HALT: begin
          if (link.irq) begin
            state_next = ST_RUN;
          end
        end
        ST_STOP: begin
          if (link.irq) begin
            // Internal high-speed source: software times its own wait
            state_next = (src_reg == CLK_INTERNAL_HS) ? ST_RUN : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (src_reg == CLK_CRYSTAL && settle_done) begin
            state_next = ST_RUN;
          end else if (src_reg == CLK_LOWSPEED && ls_hold_end) begin
            state_next = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  // Clock in use at entry is the one restored on exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_reg <= CLK_LOWSPEED;
    end else if (link.rst_req) begin
      src_reg <= CLK_LOWSPEED;
    end else if (enter_halt || enter_stop) begin
      src_reg <= cur_src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_cnt_reg <= 5'h00;
    end else if (state_reg != ST_WAIT) begin
      ls_cnt_reg <= 5'h00;
    end else if (ls_tick) begin
      ls_cnt_reg <= ls_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_reg <= SETTLE_SELECT_RST;
    end else if (link.rst_req) begin
      select_reg <= SETTLE_SELECT_RST;
    end else if (sel_wr) begin
      select_reg <= link.reg_wdata[2:0];
    end
  end

  // CPU clock only while running; held through the wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_en_reg <= 1'b0;
    end else begin
      cpu_en_reg <= (state_next == ST_RUN);
    end
  end

  // High-speed oscillator off in stop whatever clock the CPU used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_en_reg <= 1'b0;
    end else begin
      hs_en_reg <= !link.main_osc_off && (state_next != ST_STOP);
    end
  end

  // Low-speed state kept in stop, and started if it is the CPU clock: a running oscillator is never cut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_en_reg <= 1'b1;
    end else if (state_next == ST_STOP) begin
      ls_en_reg <= ls_en_reg || src_is_ls;
    end else if (state_next == ST_HALT) begin
      ls_en_reg <= ls_en_reg;
    end else begin
      ls_en_reg <= !ls_off_req;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_en_reg <= 1'b0;
      per_sel_reg <= 1'b0;
    end else begin
      per_en_reg <= (state_next != ST_STOP);
      per_sel_reg <= link.periph_clk_source;
    end
  end

  // Port latches frozen whenever the CPU is not running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
      halt_flag_reg <= 1'b0;
    end else begin
      hold_reg <= (state_next != ST_RUN);
      // Own flag, so a settle wait never reads back as halt
      halt_flag_reg <= (state_next == ST_HALT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ack_reg <= link.reg_wr || link.reg_rd;
      if (link.reg_rd) begin
        rdata_reg <= sts_hit ? {3'h0, settle_status} :
                     sel_hit ? {5'h00, select_reg} : 8'h00;
      end
    end
  end

  assign link.reg_ack    = ack_reg;
  assign link.reg_rdata  = rdata_reg;
  assign link.cpu_clk_en = cpu_en_reg;
  assign link.in_halt    = halt_flag_reg;
  assign link.in_stop    = hold_reg && !per_en_reg;
  assign link.settling   = settle_busy;
  assign hs_osc_en       = hs_en_reg;
  assign ls_osc_en       = ls_en_reg;
  assign periph_clk_en   = per_en_reg;
  assign periph_clk_sel  = per_sel_reg;
  assign hold_latches    = hold_reg;
endmodule
`default_nettype wire

// File: design/sos_host_end.sv
// CPU-side controller: APB registers driving the standby link
`timescale 1ns/1ns
`default_nettype none
module sos_host_end (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_in,
  sos_link_if.host         link
);
  import sos_pkg::*;

  logic        pready_reg;
  logic        err_reg;
  logic [31:0] prdata_reg;
  logic [5:0]  ctrl_reg;
  logic        halt_reg;
  logic        stop_reg;
  logic        rst_reg;
  logic        irq_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic        pend_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;

  wire setup    = psel && !penable && !pend_reg && !pready_reg;
  wire dev_sts  = (paddr == HOST_DEV_STS_OFF);
  wire dev_sel  = (paddr == HOST_DEV_SEL_OFF);
  wire is_dev   = dev_sts || dev_sel;
  wire is_local = (paddr == HOST_CMD_OFF) || (paddr == HOST_CTRL_OFF) || (paddr == HOST_STAT_OFF);
  wire on_ihs   = (ctrl_reg[CTRL_SRC_LSB +: 2] == CLK_INTERNAL_HS);
  // Stop from internal high-speed clock is refused
  wire bad_stop = pwrite && (paddr == HOST_CMD_OFF) && pwdata[CMD_STOP_BIT] && on_ihs;
  // Select write during a running wait is refused
  wire bad_sel  = pwrite && dev_sel && link.settling;
  wire refuse   = !(is_dev || is_local) || bad_stop || bad_sel;
  wire commit   = psel && penable && pready_reg && pwrite && !err_reg;
  wire [31:0] local_rd = (paddr == HOST_CTRL_OFF) ? {26'h0, ctrl_reg} :
                         (paddr == HOST_STAT_OFF) ?
                         {28'h0, link.settling, link.in_stop, link.in_halt, link.cpu_clk_en} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pend_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      addr_reg <= 16'h0;
      wdata_reg <= 8'h00;
    end else begin
      pready_reg <= 1'b0;
      err_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (setup && (refuse || !is_dev)) begin
        pready_reg <= 1'b1;
        err_reg <= refuse;
        prdata_reg <= local_rd;
      end else if (setup) begin
        pend_reg <= 1'b1;
        err_reg <= 1'b0;
        wr_reg <= pwrite;
        rd_reg <= !pwrite;
        addr_reg <= dev_sel ? SETTLE_SELECT_ADDR : SETTLE_STATUS_ADDR;
        wdata_reg <= pwdata[7:0];
      end else if (pend_reg && link.reg_ack) begin
        pend_reg <= 1'b0;
        pready_reg <= 1'b1;
        prdata_reg <= {24'h0, link.reg_rdata};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      halt_reg <= 1'b0;
      stop_reg <= 1'b0;
      rst_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_in;
      halt_reg <= commit && (paddr == HOST_CMD_OFF) && pwdata[CMD_HALT_BIT];
      stop_reg <= commit && (paddr == HOST_CMD_OFF) && pwdata[CMD_STOP_BIT];
      rst_reg <= commit && (paddr == HOST_CMD_OFF) && pwdata[CMD_RST_BIT];
      if (commit && (paddr == HOST_CTRL_OFF)) begin
        ctrl_reg <= pwdata[5:0];
      end
    end
  end

  assign prdata                 = prdata_reg;
  assign pready                 = pready_reg;
  assign pslverr                = err_reg;
  assign link.halt_req          = halt_reg;
  assign link.stop_req          = stop_reg;
  assign link.rst_req           = rst_reg;
  assign link.irq               = irq_reg;
  assign link.main_osc_off      = ctrl_reg[CTRL_MAIN_OFF_BIT];
  assign link.lowspeed_osc_off  = ctrl_reg[CTRL_LS_OFF_BIT];
  assign link.periph_clk_source = ctrl_reg[CTRL_PERIPH_BIT];
  assign link.cpu_clk_src       = ctrl_reg[CTRL_SRC_LSB +: 2];
  assign link.reg_wr            = wr_reg;
  assign link.reg_rd            = rd_reg;
  assign link.reg_addr          = addr_reg;
  assign link.reg_wdata         = wdata_reg;
endmodule
`default_nettype wire

// File: verif/sos_assertions.sv
// Concurrent checks on the link between the two standby ends
`timescale 1ns/1ns
`default_nettype none
module sos_assertions
  import sos_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        halt_req,
  input wire logic        stop_req,
  input wire logic        rst_req,
  input wire logic        irq,
  input wire logic [1:0]  cpu_clk_src,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_ack,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cpu_clk_en,
  input wire logic        in_halt,
  input wire logic        in_stop,
  input wire logic        settling
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_halt_gates_cpu: assert property (halt_req && cpu_clk_en && !rst_req |=> in_halt && !cpu_clk_en)
    else $error("halt request did not gate the cpu clock");
  a_halt_irq_wake: assert property (in_halt && irq && !rst_req |=> cpu_clk_en)
    else $error("interrupt did not end halt at once");
  a_stop_entry_gate: assert property (stop_req && !halt_req && !rst_req && cpu_clk_en |=> in_stop && !cpu_clk_en)
    else $error("stop request did not stop the clock");
  // Shortest trimmed wait is 16 cycles, so 8 idle cycles is always owed
  a_stop_release_waits: assert property ($fell(in_stop) && !cpu_clk_en && cpu_clk_src != 2'h2 |-> !cpu_clk_en [*8])
    else $error("cpu clock returned without a settle wait");
  a_standby_mode_holds: assert property ((in_halt || in_stop) && !irq && !rst_req |=> $stable(in_halt) && $stable(in_stop))
    else $error("standby mode left without a cause");
  a_soft_reset_run: assert property (rst_req |=> cpu_clk_en && !in_halt && !in_stop)
    else $error("reset did not end standby");
  a_stop_status_zero: assert property (in_stop && !settling && reg_rd && reg_addr == SETTLE_STATUS_ADDR |=> reg_rdata == 8'h00)
    else $error("status not cleared in stop");
  a_status_in_order: assert property ($past(reg_rd && reg_addr == SETTLE_STATUS_ADDR) && reg_ack
      |-> reg_rdata inside {8'h00, 8'h10, 8'h18, 8'h1c, 8'h1e, 8'h1f})
    else $error("status steps not set lowest first");
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench: host end and device end joined across the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sos_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        irq_in = 1'b0;
  logic        x1_tick = 1'b0;
  logic        ls_tick = 1'b0;
  logic        hs_is_internal = 1'b0;
  logic        lowspeed_can_stop = 1'b0;
  logic [1:0]  ls_div = 2'h0;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, hs_osc_en, ls_osc_en, periph_clk_en, periph_clk_sel, hold_latches;
  int          mismatches = 0;
  int          total_checks = 0;
  int          nc, nx, nl;
  logic [31:0] r;
  logic        e;

  sos_link_if link_bus();
  sos_device_end #(.EXP_TRIM(8), .LS_HOLD(21)) i_sos_device_end (.pclk(pclk), .presetn(presetn),
    .link(link_bus.device), .x1_tick(x1_tick), .ls_tick(ls_tick), .hs_is_internal(hs_is_internal),
    .lowspeed_can_stop(lowspeed_can_stop), .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en),
    .periph_clk_en(periph_clk_en), .periph_clk_sel(periph_clk_sel), .hold_latches(hold_latches));
  sos_host_end i_sos_host_end (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
    .link(link_bus.host));
  sos_assertions i_sos_assertions (.pclk(pclk), .presetn(presetn), .halt_req(link_bus.halt_req),
    .stop_req(link_bus.stop_req), .rst_req(link_bus.rst_req), .irq(link_bus.irq), .cpu_clk_src(link_bus.cpu_clk_src),
    .reg_rd(link_bus.reg_rd), .reg_addr(link_bus.reg_addr), .reg_ack(link_bus.reg_ack),
    .reg_rdata(link_bus.reg_rdata), .cpu_clk_en(link_bus.cpu_clk_en), .in_halt(link_bus.in_halt),
    .in_stop(link_bus.in_stop), .settling(link_bus.settling));

  always #20 pclk = ~pclk;
  // Crystal ticks only while its oscillator is enabled, every other cycle
  always @(posedge pclk) begin
    x1_tick <= hs_osc_en & ~x1_tick;
    ls_div <= ls_div + 2'h1;
    ls_tick <= (ls_div == 2'h3) & ls_osc_en;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic timed_out();
    mismatches++;
    give_verdict();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    apb(1'b1, a, d);
    check("pslverr", 32'(e), 32'(xe));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, r, x);
  endtask

  task automatic wait_settling(input logic want);
    int n;
    n = 0;
    while (link_bus.settling !== want && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) timed_out();
  endtask

  // Counts cycles and ticks until the cpu clock is back
  task automatic wait_cpu();
    nc = 0;
    nx = 0;
    nl = 0;
    irq_in <= 1'b1;
    do begin
      @(posedge pclk);
      nc++;
      nx += int'(x1_tick);
      nl += int'(ls_tick);
    end while (link_bus.cpu_clk_en !== 1'b1 && nc < 2000);
    if (nc >= 2000) timed_out();
    irq_in <= 1'b0;
  endtask

  task automatic enter(input logic [31:0] cmd);
    wr(HOST_CMD_OFF, cmd, 1'b0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic t_reset();
    rd(HOST_DEV_SEL_OFF, 32'h5, "select reset");
    wait_settling(1'b0);
    rd(HOST_DEV_STS_OFF, 32'h1f, "status after reset");
  endtask

  task automatic t_halt();
    wr(HOST_CTRL_OFF, 32'h14, 1'b0);
    enter(32'h1);
    check("hs osc in halt", 32'(hs_osc_en), 32'h1);
    check("ls osc in halt", 32'(ls_osc_en), 32'h1);
    check("periph in halt", 32'({periph_clk_en, periph_clk_sel}), 32'h3);
    check("latches held", 32'(hold_latches), 32'h1);
    @(posedge pclk);
    rd(HOST_STAT_OFF, 32'h2, "halt status");
    wait_cpu();
    check("halt wake cycles", 32'(nc <= 3), 32'h1);
  endtask

  task automatic t_stop(input logic [2:0] code, input logic [31:0] mask, input int n);
    wr(HOST_DEV_SEL_OFF, 32'(code), 1'b0);
    enter(32'h2);
    check("hs osc in stop", 32'(hs_osc_en), 32'h0);
    check("periph in stop", 32'(periph_clk_en), 32'h0);
    @(posedge pclk);
    rd(HOST_DEV_STS_OFF, 32'h0, "status at stop");
    rd(HOST_DEV_SEL_OFF, 32'(code), "select kept");
    wait_cpu();
    check("crystal wait", 32'(nx >= n && nx <= n + 3), 32'h1);
    rd(HOST_DEV_STS_OFF, mask, "status after wait");
    rd(HOST_STAT_OFF, 32'h1, "running again");
  endtask

  task automatic t_lowspeed();
    lowspeed_can_stop <= 1'b1;
    wr(HOST_CTRL_OFF, 32'h12, 1'b0);
    @(posedge pclk);
    check("ls osc stopped", 32'(ls_osc_en), 32'h0);
    wr(HOST_CTRL_OFF, 32'h06, 1'b0);
    enter(32'h2);
    check("ls osc in stop", 32'(ls_osc_en), 32'h1);
    check("hs osc off", 32'(hs_osc_en), 32'h0);
    @(posedge pclk);
    wait_cpu();
    check("lowspeed hold", 32'(nl >= 21 && nl <= 23), 32'h1);
    check("periph source", 32'(periph_clk_sel), 32'h1);
  endtask

  task automatic t_refuse();
    wr(HOST_CTRL_OFF, 32'h20, 1'b0);
    wr(HOST_CMD_OFF, 32'h2, 1'b1);
    rd(HOST_STAT_OFF, 32'h1, "stop refused");
    wr(8'h20, 32'h0, 1'b1);
    wr(HOST_CTRL_OFF, 32'h11, 1'b0);
    rd(HOST_DEV_STS_OFF, 32'h0, "status main off");
    wr(HOST_CTRL_OFF, 32'h10, 1'b0);
    // Only reset release, a soft reset or a stop release restarts the settle count
    wr(HOST_CMD_OFF, 32'h4, 1'b0);
    wait_settling(1'b1);
    wr(HOST_DEV_SEL_OFF, 32'h1, 1'b1);
    rd(HOST_DEV_SEL_OFF, 32'h5, "select unchanged");
  endtask

  task automatic t_soft_reset();
    wait_settling(1'b0);
    wr(HOST_CMD_OFF, 32'h1, 1'b0);
    hs_is_internal <= 1'b1;
    enter(32'h4);
    check("reset ends halt", 32'({link_bus.cpu_clk_en, link_bus.in_halt}), 32'h2);
    check("no settle on internal", 32'(link_bus.settling), 32'h0);
    @(posedge pclk);
    rd(HOST_DEV_SEL_OFF, 32'h5, "select after reset");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_halt();
    t_stop(3'h1, 32'h10, 8);
    t_stop(3'h2, 32'h18, 32);
    t_stop(3'h3, 32'h1c, 64);
    t_stop(3'h4, 32'h1e, 128);
    t_stop(3'h5, 32'h1f, 256);
    t_stop(3'h7, 32'h1f, 256);
    t_refuse();
    t_lowspeed();
    t_soft_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
